/* File: src/slcc_connect.v */
// connect control of a scan path linking gateway
// assumes core_clk at 250 MHz oversamples the primary test clock pins;
// a protocol receiver outside delivers decoded select messages as pulses
// Contract
// - ignore protocols in Exit1-DR, Exit2-DR and Update-DR
// - ignore protocols in Capture-IR through Update-IR, except Pause-IR
// - accept protocols and recognise test sync address in Pause-DR
// - accept protocols and recognise test sync address in Pause-IR
// - connect status from latest address versus node and global addresses
// - zero reset, 3fe disconnect, 3ff multicast, own on, else off
// - on full match send acknowledge, then enter ON status
// - mismatch: OFF at once, no acknowledge, outputs off, mode selects held
// - disconnect address: OFF at once, scan outputs off, mode selects held
// - reset address: RESET at once, mode select outputs forced high
// - test sync: MULTICAST, routed only to paused secondaries, no ack
// - secondaries in reset or idle are dropped from the multicast
// - monitor follows standard TAP diagram on mode select at clock rise
// - monitor starts in Test-Logic-Reset, test reset forces it there
// - reset and idle accept protocols but not the test sync address
// - message is 10 address, 3 position, 3 config bits, lsb first
`include "slcc_regs.vh"
module slcc_connect #(
  parameter NSEC = 3
) (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire primary_test_clock,
  input wire primary_mode_select,
  input wire primary_scan_in,
  input wire primary_test_reset_n,
  input wire bypass_n,
  input wire [NSEC-1:0] bypass_cfg,
  input wire [`SLCC_ADDR_W-1:0] node_address_inputs,
  input wire [`SLCC_POS_W-1:0] slot_position_inputs,
  input wire msg_valid,
  input wire [`SLCC_ADDR_W-1:0] msg_addr,
  input wire [`SLCC_POS_W-1:0] msg_pos,
  input wire [`SLCC_CFG_W-1:0] msg_cfg,
  input wire [NSEC-1:0] sec_paused,
  input wire [NSEC-1:0] sec_secondary_scan_in,
  output wire proto_enable,
  output wire tsync_enable,
  output reg ack_active,
  output reg ack_bit,
  output reg primary_scan_out,
  output reg primary_scan_out_oe,
  output reg [NSEC-1:0] secondary_scan_out,
  output reg [NSEC-1:0] secondary_scan_out_oe,
  output reg [NSEC-1:0] secondary_mode_select,
  output reg [3:0] status_reg
);
  // ****************************************************************
  // tap monitor states
  // ****************************************************************
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDR = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIR = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;
  localparam integer ACK_MSG_N = `SLCC_ACK_BITS;

  wire [4:0] pin_s;
  wire tck_s = pin_s[0];
  wire tms_s = pin_s[1];
  wire tdi_s = pin_s[2];
  // active-low pins pass inverted, so a cleared flop reads as released
  wire trst_n_s = ~pin_s[3];
  wire byp_n_s = ~pin_s[4];
  wire [NSEC-1:0] bcfg_s;
  slcc_sync #(.W(5)) u_sync_pins (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .d({~bypass_n, ~primary_test_reset_n, primary_scan_in,
        primary_mode_select, primary_test_clock}),
    .q(pin_s)
  );
  slcc_sync #(.W(NSEC)) u_sync_cfg (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .d(bypass_cfg),
    .q(bcfg_s)
  );

  reg tck_d_reg;
  reg [15:0] tap_reg;
  reg [15:0] tap_next;
  reg [NSEC-1:0] cfg_reg;
  reg [NSEC-1:0] mcast_reg;
  reg [`SLCC_ACK_BITS-1:0] ack_sh_reg;
  reg [4:0] ack_cnt_reg;
  wire tck_rise = tck_s & ~tck_d_reg;
  wire tck_fall = ~tck_s & tck_d_reg;

  // ****************************************************************
  // tap state monitor
  // ****************************************************************
  always @* begin
    tap_next = tap_reg;
    case (tap_reg)
      S_TLR: tap_next = tms_s ? S_TLR : S_RTI;
      S_RTI: tap_next = tms_s ? S_SDR : S_RTI;
      S_SDR: tap_next = tms_s ? S_SIR : S_CDR;
      S_CDR: tap_next = tms_s ? S_E1DR : S_SHDR;
      S_SHDR: tap_next = tms_s ? S_E1DR : S_SHDR;
      S_E1DR: tap_next = tms_s ? S_UDR : S_PDR;
      S_PDR: tap_next = tms_s ? S_E2DR : S_PDR;
      S_E2DR: tap_next = tms_s ? S_UDR : S_SHDR;
      S_UDR: tap_next = tms_s ? S_SDR : S_RTI;
      S_SIR: tap_next = tms_s ? S_TLR : S_CIR;
      S_CIR: tap_next = tms_s ? S_E1IR : S_SHIR;
      S_SHIR: tap_next = tms_s ? S_E1IR : S_SHIR;
      S_E1IR: tap_next = tms_s ? S_UIR : S_PIR;
      S_PIR: tap_next = tms_s ? S_E2IR : S_PIR;
      S_E2IR: tap_next = tms_s ? S_UIR : S_SHIR;
      S_UIR: tap_next = tms_s ? S_SDR : S_RTI;
      default: tap_next = S_TLR;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tck_d_reg <= 1'b0;
      tap_reg <= S_TLR;
    end else if (ce) begin
      tck_d_reg <= tck_s;
      if (!trst_n_s) begin
        tap_reg <= S_TLR;
      end else if (tck_rise) begin
        tap_reg <= tap_next;
      end
    end
  end

  // ****************************************************************
  // protocol acceptance windows
  // ****************************************************************
  // pause states: the only ones where the test sync address counts
  function slcc_in_pause;
    input [15:0] s;
    begin
      slcc_in_pause = (s == S_PDR) || (s == S_PIR);
    end
  endfunction

  // only the four stable non-shift states open the window
  function slcc_in_window;
    input [15:0] s;
    begin
      slcc_in_window = (s == S_TLR) || (s == S_RTI) || slcc_in_pause(s);
    end
  endfunction

  assign proto_enable = trst_n_s & byp_n_s &
    slcc_in_window(tap_reg);
  assign tsync_enable = proto_enable & slcc_in_pause(tap_reg);

  // ****************************************************************
  // address decode
  // ****************************************************************
  function [3:0] slcc_decode;
    input [`SLCC_ADDR_W-1:0] a;
    input [`SLCC_POS_W-1:0] p;
    input ts_ok;
    begin
      if (a == `SLCC_RESET_ADDR) begin
        slcc_decode = `SLCC_ST_RESET;
      end else if (a == `SLCC_TSYNC_ADDR && ts_ok) begin
        slcc_decode = `SLCC_ST_MCAST;
      end else if (a == `SLCC_DISC_ADDR) begin
        slcc_decode = `SLCC_ST_OFF;
      end else if (a == node_address_inputs &&
                   p == slot_position_inputs) begin
        slcc_decode = `SLCC_ST_ON;
      end else begin
        slcc_decode = `SLCC_ST_OFF;
      end
    end
  endfunction

  wire msg_take = msg_valid & proto_enable & ~ack_active;
  wire [3:0] result = slcc_decode(msg_addr, msg_pos, tsync_enable);

  // ****************************************************************
  // connect status and acknowledge
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_reg <= `SLCC_ST_OFF;
      cfg_reg <= {NSEC{1'b0}};
      mcast_reg <= {NSEC{1'b0}};
      ack_active <= 1'b0;
      ack_bit <= 1'b0;
      ack_sh_reg <= {`SLCC_ACK_BITS{1'b0}};
      ack_cnt_reg <= 5'h00;
    end else if (ce) begin
      // test reset wins, even over an acknowledge in flight
      if (!trst_n_s) begin
        status_reg <= `SLCC_ST_RESET;
        ack_active <= 1'b0;
      end else if (ack_active) begin
        if (tck_fall) begin
          ack_bit <= ack_sh_reg[0];
          ack_sh_reg <= {1'b0, ack_sh_reg[`SLCC_ACK_BITS-1:1]};
          ack_cnt_reg <= ack_cnt_reg - 5'h01;
          if (ack_cnt_reg == 5'h01) begin
            ack_active <= 1'b0;
            status_reg <= `SLCC_ST_ON;
          end
        end
      end else if (msg_take) begin
        // off first, then upgrade after acknowledge
        if (result == `SLCC_ST_ON) begin
          status_reg <= `SLCC_ST_OFF;
          cfg_reg <= msg_cfg[NSEC-1:0];
          ack_sh_reg <= {msg_cfg, msg_pos, msg_addr};
          ack_cnt_reg <= ACK_MSG_N[4:0];
          ack_active <= 1'b1;
        end else begin
          status_reg <= result;
          if (result == `SLCC_ST_MCAST) begin
            mcast_reg <= sec_paused;
          end
        end
      end
    end
  end

  // ****************************************************************
  // secondary and primary routing
  // ****************************************************************
  reg [NSEC-1:0] route;
  integer i;
  always @* begin
    if (!byp_n_s) begin
      route = bcfg_s;
    end else if (status_reg == `SLCC_ST_ON) begin
      route = cfg_reg;
    end else if (status_reg == `SLCC_ST_MCAST) begin
      route = mcast_reg;
    end else begin
      route = {NSEC{1'b0}};
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      primary_scan_out <= 1'b0;
      primary_scan_out_oe <= 1'b0;
      secondary_scan_out <= {NSEC{1'b0}};
      secondary_scan_out_oe <= {NSEC{1'b0}};
      secondary_mode_select <= {NSEC{1'b1}};
    end else if (ce) begin
      primary_scan_out <= 1'b0;
      primary_scan_out_oe <= 1'b0;
      // the acknowledge owns the primary output while it runs
      if (ack_active) begin
        primary_scan_out <= ack_bit;
        primary_scan_out_oe <= 1'b1;
      end else if (status_reg == `SLCC_ST_ON || !byp_n_s) begin
        for (i = 0; i < NSEC; i = i + 1) begin
          if (route[i]) begin
            primary_scan_out <= sec_secondary_scan_in[i];
            primary_scan_out_oe <= 1'b1;
          end
        end
      end
      for (i = 0; i < NSEC; i = i + 1) begin
        secondary_scan_out[i] <= tdi_s;
        secondary_scan_out_oe[i] <= route[i];
        if (!trst_n_s || (status_reg == `SLCC_ST_RESET && byp_n_s)) begin
          secondary_mode_select[i] <= 1'b1;
        end else if (route[i]) begin
          secondary_mode_select[i] <= tms_s;
        end
        // unrouted mode selects hold their last level
      end
    end
  end
endmodule

/* File: common/slcc_regs.vh */
// constants of the scan link connect control block
// assumes inclusion by bare name from design files
`ifndef SLCC_REGS_VH
`define SLCC_REGS_VH
`define SLCC_ADDR_W 10
`define SLCC_POS_W 3
`define SLCC_CFG_W 3
`define SLCC_RESET_ADDR 10'h000
`define SLCC_DISC_ADDR 10'h3fe
`define SLCC_TSYNC_ADDR 10'h3ff
`define SLCC_ACK_BITS 16
`define SLCC_ST_OFF 4'h1
`define SLCC_ST_ON 4'h2
`define SLCC_ST_RESET 4'h4
`define SLCC_ST_MCAST 4'h8
`endif

/* File: src/slcc_sync.v */
// two-flop synchroniser for a group of asynchronous inputs
// assumes core_clk domain, async active high reset
module slcc_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

/* File: test/slcc_monitor.sv */
// checker on the ports of the connect control block
// assumes a bind onto slcc_connect, all in the core_clk domain
`include "slcc_regs.vh"
module slcc_monitor #(parameter NSEC = 3) (
  input wire core_clk,
  input wire rst,
  input wire ce,
  input wire primary_test_reset_n,
  input wire bypass_n,
  input wire [`SLCC_ADDR_W-1:0] node_address_inputs,
  input wire [`SLCC_POS_W-1:0] slot_position_inputs,
  input wire msg_valid,
  input wire [`SLCC_ADDR_W-1:0] msg_addr,
  input wire [`SLCC_POS_W-1:0] msg_pos,
  input wire proto_enable,
  input wire tsync_enable,
  input wire ack_active,
  input wire primary_scan_out_oe,
  input wire [NSEC-1:0] secondary_scan_out_oe,
  input wire [NSEC-1:0] secondary_mode_select,
  input wire [3:0] status_reg
);
  // ****************************************
  // pins quiet for four cycles, taken message
  // ****************************************
  reg [3:0] pins_reg;
  wire ok = &pins_reg;
  wire tk = msg_valid && proto_enable && !ack_active && ok;
  wire glob = msg_addr == 10'h000 || msg_addr >= 10'h3fe;
  wire own = msg_addr == node_address_inputs
    && msg_pos == slot_position_inputs;
  always @(posedge core_clk or posedge rst)
    if (rst) pins_reg <= 4'h0;
    else pins_reg <= {pins_reg[2:0], primary_test_reset_n & bypass_n};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  chk_reset_addr: assert property (
    tk && msg_addr == 10'h000 |=> status_reg == `SLCC_ST_RESET
    && !ack_active ##1 &secondary_mode_select) else $error("reset addr");
  chk_disc_addr: assert property (
    tk && msg_addr == 10'h3fe |=> status_reg == `SLCC_ST_OFF && !ack_active
    ##1 !primary_scan_out_oe && secondary_scan_out_oe == 0)
    else $error("disconnect");
  chk_no_match: assert property (
    tk && !glob && !own |=> status_reg == `SLCC_ST_OFF && !ack_active
    ##1 !primary_scan_out_oe && secondary_scan_out_oe == 0)
    else $error("no match");
  chk_match_ack: assert property (
    tk && !glob && own |=> ack_active && status_reg == `SLCC_ST_OFF)
    else $error("match ack");
  chk_ack_end: assert property (
    ok && $fell(ack_active) |-> status_reg == `SLCC_ST_ON)
    else $error("ack end");
  chk_mcast_enter: assert property (
    tk && msg_addr == 10'h3ff && tsync_enable |=> !ack_active
    && status_reg == `SLCC_ST_MCAST ##1 !primary_scan_out_oe)
    else $error("multicast");
  chk_tsync_gate: assert property (
    tk && msg_addr == 10'h3ff && !tsync_enable |=>
    status_reg == `SLCC_ST_OFF && !ack_active) else $error("tsync gate");
  chk_ignore_msg: assert property (
    msg_valid && !proto_enable && !ack_active && ok |=>
    $stable(status_reg) && !ack_active) else $error("ignore");
  chk_trst_force: assert property (
    !primary_test_reset_n [*5] |-> status_reg == `SLCC_ST_RESET
    && &secondary_mode_select) else $error("test reset");
endmodule
bind slcc_connect slcc_monitor #(.NSEC(NSEC)) slcc_monitor_i (.core_clk,
  .rst, .ce, .primary_test_reset_n, .bypass_n, .node_address_inputs,
  .slot_position_inputs, .msg_valid, .msg_addr, .msg_pos, .proto_enable,
  .tsync_enable, .ack_active, .primary_scan_out_oe, .secondary_scan_out_oe,
  .secondary_mode_select, .status_reg);

/* File: test/slcc_master.sv */
// bus master model on the primary test pins
// assumes a 125 ns test clock that stands low between frames
module slcc_master (
  output logic primary_test_clock,
  output logic primary_mode_select,
  output logic primary_test_reset_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    primary_test_clock = 1'b0;
    primary_mode_select = 1'b1;
    primary_test_reset_n = 1'b1;
  end
  // mode select changes only while the clock is low
  task step(input logic tms);
    primary_mode_select = tms;
    #31.2 primary_test_clock = 1'b1;
    #62.5 primary_test_clock = 1'b0;
    #31.3;
  endtask
  task set_reset(input logic v);
    primary_test_reset_n = v;
  endtask
endmodule

/* File: test/tb_top.sv */
// self-checking bench of the connect control block
// assumes slcc_monitor bound to the design and slcc_master on the pins
`include "slcc_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic msg_valid = 1'b0;
  logic primary_scan_in = 1'b0;
  logic [9:0] node = 10'h155;
  logic [9:0] msg_addr = 10'h000;
  logic [2:0] slot = 3'h5;
  logic [2:0] msg_pos = 3'h0;
  logic [2:0] msg_cfg = 3'h0;
  logic [2:0] sec_paused = 3'h5;
  logic [2:0] m;
  logic ce = 1'b1;
  logic bypass_n = 1'b1;
  logic [2:0] bypass_cfg = 3'h0;
  logic [2:0] sec_in = 3'h3;
  logic [15:0] ackw;
  wire ack_bit, pso;
  // tms, protocols accepted, test sync recognised
  logic [2:0] rows [20] = '{3'h2, 3'h4, 3'h0, 3'h4, 3'h3, 3'h4, 3'h4,
    3'h4, 3'h4, 3'h0, 3'h0, 3'h4, 3'h3, 3'h4, 3'h4, 3'h4, 3'h0, 3'h0,
    3'h4, 3'h3};
  wire tck, tms, trst_n, proto_enable, tsync_enable, ack_active, pso_oe;
  wire [2:0] sso, sso_oe, sms;
  wire [3:0] st;
  int fail_count = 0;
  int comparisons = 0;
  always #2 core_clk = ~core_clk;
  slcc_master slcc_master_i (.primary_test_clock(tck),
    .primary_mode_select(tms), .primary_test_reset_n(trst_n));
  slcc_connect #(.NSEC(3)) slcc_connect_i (.core_clk, .rst, .ce,
    .primary_test_clock(tck), .primary_mode_select(tms), .primary_scan_in,
    .primary_test_reset_n(trst_n), .bypass_n, .bypass_cfg,
    .node_address_inputs(node), .slot_position_inputs(slot), .msg_valid,
    .msg_addr, .msg_pos, .msg_cfg, .sec_paused,
    .sec_secondary_scan_in(sec_in), .proto_enable, .tsync_enable,
    .ack_active, .ack_bit, .primary_scan_out(pso),
    .primary_scan_out_oe(pso_oe), .secondary_scan_out(sso),
    .secondary_scan_out_oe(sso_oe), .secondary_mode_select(sms),
    .status_reg(st));
  // ****************************************
  // tasks
  // ****************************************
  task chk(input string what, input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task send(input logic [9:0] a, input logic [2:0] p, c);
    msg_addr = a;
    msg_pos = p;
    msg_cfg = c;
    msg_valid = 1'b1;
    cyc(1);
    msg_valid = 1'b0;
    cyc(2);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(4);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    chk("mode sel", 16'(sms), 16'h7);
    chk("sec oe", 16'(sso_oe), 16'h0);
    $display("test reset finished");
    foreach (rows[i]) begin
      slcc_master_i.step(rows[i][2]);
      cyc(8);
      chk("proto", 16'(proto_enable), 16'(rows[i][1]));
      chk("tsync", 16'(tsync_enable), 16'(rows[i][0]));
    end
    $display("test tap walk finished");
    send(10'h000, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    chk("mode sel", 16'(sms), 16'h7);
    send(node, slot, 3'h3);
    chk("ack", 16'(ack_active), 16'h1);
    send(10'h3fe, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    chk("ack", 16'(ack_active), 16'h1);
    ackw = {3'h3, slot, node};
    for (int k = 0; k < 16; k++) begin
      slcc_master_i.step(1'b0);
      cyc(1);
      chk("ack bit", 16'(ack_bit), 16'(ackw[k]));
    end
    for (int i = 0; i < 20 && ack_active !== 1'b0; i++) cyc(1);
    chk("ack done", 16'(ack_active), 16'h0);
    cyc(2);
    chk("status", 16'(st), 16'(`SLCC_ST_ON));
    chk("sec oe", 16'(sso_oe), 16'h3);
    chk("prim oe", 16'(pso_oe), 16'h1);
    chk("prim out", 16'(pso), 16'h1);
    $display("test match finished");
    m = sms;
    send(node, 3'h4, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    chk("mode sel", 16'(sms), 16'(m));
    chk("sec oe", 16'(sso_oe), 16'h0);
    primary_scan_in = 1'b1;
    send(10'h3ff, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_MCAST));
    chk("sec oe", 16'(sso_oe), 16'h5);
    chk("sec out", 16'(sso & sec_paused), 16'h5);
    chk("prim oe", 16'(pso_oe), 16'h0);
    send(10'h3fe, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    chk("sec oe", 16'(sso_oe), 16'h0);
    $display("test global finished");
    slcc_master_i.step(1'b1);
    cyc(8);
    send(node, slot, 3'h3);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    chk("ack", 16'(ack_active), 16'h0);
    slcc_master_i.step(1'b1);
    slcc_master_i.step(1'b0);
    cyc(8);
    send(10'h000, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    chk("mode sel", 16'(sms), 16'h7);
    send(10'h3ff, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_OFF));
    slcc_master_i.set_reset(1'b0);
    cyc(8);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    chk("mode sel", 16'(sms), 16'h7);
    slcc_master_i.set_reset(1'b1);
    cyc(8);
    chk("proto", 16'(proto_enable), 16'h1);
    chk("tsync", 16'(tsync_enable), 16'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    $display("test trst finished");
    ce = 1'b0;
    send(10'h3fe, 3'h0, 3'h0);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    ce = 1'b1;
    cyc(2);
    $display("test enable finished");
    bypass_cfg = 3'h6;
    bypass_n = 1'b0;
    cyc(6);
    chk("sec oe", 16'(sso_oe), 16'h6);
    chk("prim oe", 16'(pso_oe), 16'h1);
    chk("proto", 16'(proto_enable), 16'h0);
    bypass_n = 1'b1;
    cyc(6);
    chk("status", 16'(st), 16'(`SLCC_ST_RESET));
    chk("sec oe", 16'(sso_oe), 16'h0);
    chk("mode sel", 16'(sms), 16'h7);
    $display("test bypass finished");
    report_and_stop();
  end
endmodule
